// *** src/mgmt_irq_pkg.sv ***
// Constants, register map and types for the management interrupt block
package mgmt_irq_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned DEBOUNCE_MS = 16;
    localparam int unsigned OVERRIDE_S = 4;
    localparam int unsigned DEBOUNCE_CYC_DEF = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int unsigned OVERRIDE_CYC_DEF = CLK_HZ * OVERRIDE_S;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned EOI_GAP_CYC = 1;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_ENABLE = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0c;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int unsigned CTRL_GLOBAL_EN = 0;
    localparam int unsigned CTRL_EOH = 1;
    localparam int unsigned CTRL_ROUTE = 2;
    localparam int unsigned CTRL_COVER_POL = 3;
    localparam int unsigned CTRL_OVR_EN = 4;

    // ------------------------------------------------------------
    // Status / enable / mask fields
    // ------------------------------------------------------------
    localparam int unsigned NUM_EV = 3;
    localparam int unsigned EV_BUTTON = 0;
    localparam int unsigned EV_COVER = 1;
    localparam int unsigned EV_OVERRIDE = 2;
    localparam int unsigned ST_SUMMARY = 8;

    localparam logic [NUM_EV-1:0] EV_RESET = 3'h0;
    localparam logic [NUM_EV-1:0] WAKE_EVENTS = 3'h3;

    typedef enum logic [1:0] {
        IRQ_ARMED,
        IRQ_ACTIVE,
        IRQ_GAP
    } irq_state_t;

endpackage : mgmt_irq_pkg

// *** src/input_debounce.sv ***
// Synchronise and debounce one input pin
`timescale 1ns/1ps
`default_nettype none
module input_debounce #(
    parameter logic [31:0] HOLD_CYC = 32'd1_600_000
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Pin and filtered level
    input wire logic pin_i,
    output logic level_o
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic level;
        logic [31:0] cnt;
    } deb_state_t;

    deb_state_t s_q;
    deb_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.sync1 = pin_i;
        s_d.sync2 = s_q.sync1;
        // Level moves only after it has held still the whole window
        if (s_q.sync2 == s_q.level) begin
            s_d.cnt = 32'h0;
        end else if (s_q.cnt >= HOLD_CYC - 32'h1) begin
            s_d.level = s_q.sync2;
            s_d.cnt = 32'h0;
        end else begin
            s_d.cnt = s_q.cnt + 32'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.level;

endmodule : input_debounce
`default_nettype wire

// *** src/system_mgmt_interrupt_gen.sv ***
// Management interrupt generation with power button and cover switch inputs
// Functional notes
// - Management interrupts appear only while the global enable bit is set.
// - An enabled event clears the end-of-handler bit and mgmt_irq_n is held low until the bit is set again.
// - Events during an open handler still set status but add no further assertion.
// - Setting the end-of-handler bit drives mgmt_irq_n high for at least one clock before reassertion.
// - Setting the bit while enabled status is pending in an open handler leaves it clear and keeps mgmt_irq_n low.
// - A write setting the bit has no effect in an open handler while any enabled status bit remains set.
// - The route select bit sends enabled events to the ACPI interrupt when 1, else to the management interrupt.
// - Each event sets its own status bit and the bits, gated by the enable register, are ORed into a summary bit.
// - The summary bit ignores software clears and falls only when all enabled children are clear.
// - The power button is debounced for 16 ms and then sets its status and may interrupt.
// - A button held beyond 4 s with override enabled clears button status, sets override status and requests soft-off.
// - The cover switch is debounced for 16 ms and then sets its status and may interrupt.
// - A polarity bit chooses which cover switch level counts as asserted.
// - Button and cover events can also raise the ACPI interrupt or a wake request.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module system_mgmt_interrupt_gen #(
    parameter logic [31:0] DEBOUNCE_CYC = 32'(mgmt_irq_pkg::DEBOUNCE_CYC_DEF),
    parameter logic [31:0] OVERRIDE_CYC = 32'(mgmt_irq_pkg::OVERRIDE_CYC_DEF)
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Pins from the board
    input wire logic power_button_n_i,
    input wire logic cover_switch_i,
    // Toward processor and power sequencer
    output logic mgmt_irq_n_o,
    output logic acpi_irq_o,
    output logic wake_o,
    output logic soft_off_o,
    // Masked interrupt of the status block
    output logic irq_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic global_en;
        logic eoh;
        logic route;
        logic cover_pol;
        logic ovr_en;
        logic [mgmt_irq_pkg::NUM_EV-1:0] status;
        logic [mgmt_irq_pkg::NUM_EV-1:0] enable;
        logic [mgmt_irq_pkg::NUM_EV-1:0] mask;
        logic btn_prev;
        logic cover_prev;
        logic ovr_done;
        logic [mgmt_irq_pkg::CNT_W-1:0] hold_cnt;
        mgmt_irq_pkg::irq_state_t st;
        logic mgmt_irq_n;
        logic acpi_irq;
        logic wake;
        logic soft_off;
        logic [31:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic btn_level;
    logic cover_level;
    logic cover_asserted;
    logic [mgmt_irq_pkg::NUM_EV-1:0] ev_set;
    logic [mgmt_irq_pkg::NUM_EV-1:0] wr_clear;
    logic [mgmt_irq_pkg::NUM_EV-1:0] status_next;
    logic summary;
    logic wr_ctrl;
    logic eoh_write;

    // ------------------------------------------------------------
    // Input filters
    // ------------------------------------------------------------
    // Button debounce
    input_debounce #(
        .HOLD_CYC(DEBOUNCE_CYC)
    ) u_btn_deb (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .pin_i(~power_button_n_i),
        .level_o(btn_level)
    );

    input_debounce #(
        .HOLD_CYC(DEBOUNCE_CYC)
    ) u_cover_deb (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .pin_i(cover_switch_i),
        .level_o(cover_level)
    );

    assign cover_asserted = s_q.cover_pol ? cover_level : ~cover_level;

    // ------------------------------------------------------------
    // Events and status
    // ------------------------------------------------------------
    assign wr_ctrl = reg_wr_i && (reg_addr_i == mgmt_irq_pkg::ADDR_CTRL);
    assign eoh_write = wr_ctrl && reg_wdata_i[mgmt_irq_pkg::CTRL_EOH];

    always_comb begin
        ev_set = '0;
        ev_set[mgmt_irq_pkg::EV_BUTTON] = btn_level && !s_q.btn_prev;
        ev_set[mgmt_irq_pkg::EV_COVER] = cover_asserted && !s_q.cover_prev;
        ev_set[mgmt_irq_pkg::EV_OVERRIDE] = s_q.ovr_en && btn_level && !s_q.ovr_done
            && (s_q.hold_cnt >= OVERRIDE_CYC - 32'h1);
    end

    assign wr_clear = (reg_wr_i && reg_addr_i == mgmt_irq_pkg::ADDR_STATUS)
        ? reg_wdata_i[mgmt_irq_pkg::NUM_EV-1:0] : '0;

    genvar g;
    generate
        for (g = 0; g < mgmt_irq_pkg::NUM_EV; g++) begin : g_status
            // Write one clears, a new event wins over the clear
            if (g == mgmt_irq_pkg::EV_BUTTON) begin : g_btn
                assign status_next[g] = ev_set[g]
                    || (s_q.status[g] && !wr_clear[g] && !ev_set[mgmt_irq_pkg::EV_OVERRIDE]);
            end else begin : g_other
                assign status_next[g] = ev_set[g] || (s_q.status[g] && !wr_clear[g]);
            end
        end
    endgenerate

    // No clear path of its own, it follows its children
    assign summary = |(s_q.status & s_q.enable);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.status = status_next;
        s_d.btn_prev = btn_level;
        s_d.cover_prev = cover_asserted;

        // Long press timer, runs only while the button is held
        if (!btn_level) begin
            s_d.hold_cnt = '0;
            s_d.ovr_done = 1'b0;
        end else if (ev_set[mgmt_irq_pkg::EV_OVERRIDE]) begin
            s_d.ovr_done = 1'b1;
        end else if (!s_q.ovr_done) begin
            s_d.hold_cnt = s_q.hold_cnt + 32'h1;
        end

        if (ev_set[mgmt_irq_pkg::EV_OVERRIDE]) begin
            s_d.soft_off = 1'b1;
        end

        if (reg_wr_i) begin
            case (reg_addr_i)
                mgmt_irq_pkg::ADDR_CTRL: begin
                    s_d.global_en = reg_wdata_i[mgmt_irq_pkg::CTRL_GLOBAL_EN];
                    s_d.route = reg_wdata_i[mgmt_irq_pkg::CTRL_ROUTE];
                    s_d.cover_pol = reg_wdata_i[mgmt_irq_pkg::CTRL_COVER_POL];
                    s_d.ovr_en = reg_wdata_i[mgmt_irq_pkg::CTRL_OVR_EN];
                end
                mgmt_irq_pkg::ADDR_ENABLE: begin
                    s_d.enable = reg_wdata_i[mgmt_irq_pkg::NUM_EV-1:0];
                end
                mgmt_irq_pkg::ADDR_MASK: begin
                    s_d.mask = reg_wdata_i[mgmt_irq_pkg::NUM_EV-1:0];
                end
                default: begin
                end
            endcase
        end

        // Handshake with the handler
        case (s_q.st)
            mgmt_irq_pkg::IRQ_ARMED: begin
                s_d.mgmt_irq_n = 1'b1;
                // Only when routed to the management interrupt
                if (s_q.global_en && !s_q.route && s_q.eoh && summary) begin
                    s_d.eoh = 1'b0;
                    s_d.mgmt_irq_n = 1'b0;
                    s_d.st = mgmt_irq_pkg::IRQ_ACTIVE;
                end else if (eoh_write) begin
                    s_d.eoh = 1'b1;
                end
            end
            mgmt_irq_pkg::IRQ_ACTIVE: begin
                // Held low, new events only mark status
                s_d.mgmt_irq_n = 1'b0;
                if (eoh_write && !summary) begin
                    s_d.eoh = 1'b1;
                    s_d.mgmt_irq_n = 1'b1;
                    s_d.st = mgmt_irq_pkg::IRQ_GAP;
                end
            end
            mgmt_irq_pkg::IRQ_GAP: begin
                // Stays high this cycle whatever arrives
                s_d.mgmt_irq_n = 1'b1;
                s_d.st = mgmt_irq_pkg::IRQ_ARMED;
                // Pending work reasserts from ARMED next cycle
            end
            default: begin
                s_d.st = mgmt_irq_pkg::IRQ_ARMED;
                s_d.mgmt_irq_n = 1'b1;
            end
        endcase

        // ACPI path, level while routed and pending
        // Button and cover also usable as ACPI sources
        s_d.acpi_irq = s_q.route && summary;
        // Wake request from button or cover
        s_d.wake = |(s_q.status & s_q.enable & mgmt_irq_pkg::WAKE_EVENTS);

        // Read data valid only in the cycle after the strobe
        s_d.rdata = 32'h0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                mgmt_irq_pkg::ADDR_CTRL: begin
                    s_d.rdata[mgmt_irq_pkg::CTRL_GLOBAL_EN] = s_q.global_en;
                    s_d.rdata[mgmt_irq_pkg::CTRL_EOH] = s_q.eoh;
                    s_d.rdata[mgmt_irq_pkg::CTRL_ROUTE] = s_q.route;
                    s_d.rdata[mgmt_irq_pkg::CTRL_COVER_POL] = s_q.cover_pol;
                    s_d.rdata[mgmt_irq_pkg::CTRL_OVR_EN] = s_q.ovr_en;
                end
                mgmt_irq_pkg::ADDR_STATUS: begin
                    s_d.rdata[mgmt_irq_pkg::NUM_EV-1:0] = s_q.status;
                    s_d.rdata[mgmt_irq_pkg::ST_SUMMARY] = summary;
                end
                mgmt_irq_pkg::ADDR_ENABLE: begin
                    s_d.rdata[mgmt_irq_pkg::NUM_EV-1:0] = s_q.enable;
                end
                mgmt_irq_pkg::ADDR_MASK: begin
                    s_d.rdata[mgmt_irq_pkg::NUM_EV-1:0] = s_q.mask;
                end
                default: begin
                    s_d.rdata = 32'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.mgmt_irq_n <= 1'b1;
            s_q.st <= mgmt_irq_pkg::IRQ_ARMED;
            s_q.status <= mgmt_irq_pkg::EV_RESET;
            // Filter level resets low, which reads as asserted with polarity 0; no false edge
            s_q.cover_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign mgmt_irq_n_o = s_q.mgmt_irq_n;
    assign acpi_irq_o = s_q.acpi_irq;
    assign wake_o = s_q.wake;
    assign soft_off_o = s_q.soft_off;
    assign reg_rdata_o = s_q.rdata;
    // Local level interrupt, independent of the handler handshake
    assign irq_o = |(s_q.status & s_q.mask);

endmodule : system_mgmt_interrupt_gen
`default_nettype wire

// *** tb/system_mgmt_interrupt_gen_sva.sv ***
// Assertion checker for the management interrupt block
`timescale 1ns/1ps
`default_nettype none
module mgmt_irq_sva #(
    parameter logic [31:0] DEBOUNCE_CYC = 32'h8,
    parameter logic [31:0] OVERRIDE_CYC = 32'h32
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // Outputs watched
    input wire logic mgmt_irq_n_o,
    input wire logic acpi_irq_o,
    input wire logic wake_o,
    input wire logic soft_off_o
);
    logic [4:0] ctrl_q;
    logic [2:0] en_q;
    wire ctrl_wr = reg_wr_i && reg_addr_i == mgmt_irq_pkg::ADDR_CTRL;
    wire eoh_wr = ctrl_wr && reg_wdata_i[mgmt_irq_pkg::CTRL_EOH];
    // Shadow of the control and enable registers, seen from the bus only
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl_q <= 5'h0;
            en_q <= 3'h0;
        end else begin
            if (ctrl_wr) begin
                ctrl_q <= reg_wdata_i[4:0];
            end
            if (reg_wr_i && reg_addr_i == mgmt_irq_pkg::ADDR_ENABLE) begin
                en_q <= reg_wdata_i[2:0];
            end
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence irq_release;
        $rose(mgmt_irq_n_o);
    endsequence
    sequence status_read;
        $past(reg_rd_i && reg_addr_i == mgmt_irq_pkg::ADDR_STATUS);
    endsequence
    a_release_gap: assert property (irq_release |=> mgmt_irq_n_o)
        else $error("interrupt released for less than two cycles");
    a_release_cause: assert property (irq_release |-> $past(eoh_wr) || $past(eoh_wr, 2))
        else $error("interrupt released without an end-of-handler write");
    a_global_gate: assert property (!ctrl_q[0] && mgmt_irq_n_o |=> mgmt_irq_n_o)
        else $error("interrupt asserted while globally disabled");
    a_route_fall: assert property ($fell(mgmt_irq_n_o) |-> $past(ctrl_q[0] && !ctrl_q[2]))
        else $error("interrupt asserted while routed to acpi");
    a_acpi_route: assert property (acpi_irq_o |-> $past(ctrl_q[2]))
        else $error("acpi interrupt raised while routed to management");
    a_summary_or: assert property (status_read |-> reg_rdata_o[8] == |(reg_rdata_o[2:0] & $past(en_q)))
        else $error("summary bit differs from enabled leaf status");
    a_soft_off_hold: assert property (soft_off_o |=> soft_off_o)
        else $error("soft-off request dropped before reset");
    a_wake_cause: assert property (wake_o |-> $past(|en_q[1:0]))
        else $error("wake request with no wake source enabled");
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside the read answer cycle");
endmodule : mgmt_irq_sva

bind system_mgmt_interrupt_gen mgmt_irq_sva #(
    .DEBOUNCE_CYC(DEBOUNCE_CYC),
    .OVERRIDE_CYC(OVERRIDE_CYC)
) chk (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .mgmt_irq_n_o(mgmt_irq_n_o),
    .acpi_irq_o(acpi_irq_o),
    .wake_o(wake_o),
    .soft_off_o(soft_off_o)
);
`default_nettype wire

// *** tb/host_model.sv ***
// Behavioural host processor counting management interrupt entries
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Interrupt from the block
    input wire logic mgmt_irq_n_i,
    // Handler entries seen
    output var int entries_o
);
    logic prev_q;
    // one entry per low level after a high one
    always_ff @(posedge sys_clk_i) begin
        prev_q <= mgmt_irq_n_i;
        if (rst_i) begin
            entries_o <= 0;
        end else if (prev_q && !mgmt_irq_n_i) begin
            entries_o <= entries_o + 1;
        end
    end
endmodule : host_model
`default_nettype wire

// *** tb/system_mgmt_interrupt_gen_test.sv ***
// Self-checking bench for the management interrupt block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run += 1; if ((got) !== (ex)) begin err_count += 1; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module system_mgmt_interrupt_gen_test;
    localparam int DB = 8;
    localparam int OV = 50;
    localparam logic [7:0] CT = mgmt_irq_pkg::ADDR_CTRL;
    localparam logic [7:0] ST = mgmt_irq_pkg::ADDR_STATUS;
    localparam logic [7:0] EN = mgmt_irq_pkg::ADDR_ENABLE;
    localparam logic [7:0] MK = mgmt_irq_pkg::ADDR_MASK;
    typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r;} row_t;
    // Pol flip in the ctrl row may set cover status; the last row clears it
    localparam row_t ROWS [8] = '{'{EN, 32'hffffffff, 32'h7}, '{MK, 32'hffffffff, 32'h7},
        '{8'h10, 32'hffffffff, 32'h0}, '{CT, 32'h1d, 32'h1d}, '{CT, 32'h0, 32'h0},
        '{EN, 32'h0, 32'h0}, '{MK, 32'h0, 32'h0}, '{ST, 32'h7, 32'h0}};
    logic sys_clk_i;
    logic rst_i;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [31:0] reg_rdata_o;
    logic power_button_n_i;
    logic cover_switch_i;
    logic mgmt_irq_n_o;
    logic acpi_irq_o;
    logic wake_o;
    logic soft_off_o;
    logic irq_o;
    logic [31:0] rd_v;
    int entries;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;

    system_mgmt_interrupt_gen #(.DEBOUNCE_CYC(32'(DB)), .OVERRIDE_CYC(32'(OV))) dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .power_button_n_i(power_button_n_i), .cover_switch_i(cover_switch_i),
        .mgmt_irq_n_o(mgmt_irq_n_o), .acpi_irq_o(acpi_irq_o), .wake_o(wake_o),
        .soft_off_o(soft_off_o), .irq_o(irq_o));
    host_model host (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .mgmt_irq_n_i(mgmt_irq_n_o), .entries_o(entries));

    initial begin
        sys_clk_i = 1'h0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc += 1;
        if (cyc == 3000) begin
            err_count += 1;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'h1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'h1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'h0;
        #1;
        rd_v = reg_rdata_o;
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : wt
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_i = 1'h1;
        reg_addr_i = 8'h0;
        reg_wdata_i = 32'h0;
        reg_wr_i = 1'h0;
        reg_rd_i = 1'h0;
        power_button_n_i = 1'h1;
        cover_switch_i = 1'h1;
        wt(8);
        rst_i <= 1'h0;
        for (int i = 0; i < 4; i++) begin
            rd(8'(i * 4));
            `CHK("reset value", 32'h0, rd_v)
        end
        for (int i = 0; i < 8; i++) begin
            wr(ROWS[i].a, ROWS[i].w);
            rd(ROWS[i].a);
            `CHK("register", ROWS[i].r, rd_v)
        end
        // Armed handler, then a second event while it is open
        wr(EN, 32'h3);
        wr(MK, 32'h1);
        wr(CT, 32'h3);
        wt(1);
        power_button_n_i <= 1'h0;
        wt(DB + 12);
        power_button_n_i <= 1'h1;
        cover_switch_i <= 1'h0;
        #1;
        `CHK("mgmt low", 1'h0, mgmt_irq_n_o)
        `CHK("local irq", 1'h1, irq_o)
        rd(CT);
        `CHK("eoh cleared", 1'h0, rd_v[1])
        wt(DB + 12);
        rd(ST);
        `CHK("status", 9'h103, rd_v[8:0])
        `CHK("entries", 1, entries)
        wr(MK, 32'h0);
        #1;
        `CHK("masked irq", 1'h0, irq_o)
        wr(ST, 32'h1);
        wr(CT, 32'h3);
        rd(CT);
        `CHK("eoh refused", 1'h0, rd_v[1])
        `CHK("mgmt held", 1'h0, mgmt_irq_n_o)
        wr(ST, 32'h2);
        wr(CT, 32'h3);
        wt(2);
        #1;
        `CHK("mgmt released", 1'h1, mgmt_irq_n_o)
        rd(CT);
        `CHK("eoh set", 1'h1, rd_v[1])
        power_button_n_i <= 1'h0;
        wt(DB + 12);
        power_button_n_i <= 1'h1;
        `CHK("reassert", 2, entries)
        wr(ST, 32'h7);
        wr(CT, 32'h3);
        // Acpi routing with cover polarity high, pin rising
        wr(CT, 32'hd);
        wt(1);
        cover_switch_i <= 1'h1;
        wt(DB + 12);
        #1;
        `CHK("acpi", 1'h1, acpi_irq_o)
        `CHK("mgmt idle", 1'h1, mgmt_irq_n_o)
        `CHK("wake", 1'h1, wake_o)
        rd(ST);
        `CHK("cover rising", 3'h2, rd_v[2:0])
        wr(ST, 32'h7);
        wt(2);
        #1;
        `CHK("acpi cleared", 1'h0, acpi_irq_o)
        // Override with the global enable off
        wr(CT, 32'h18);
        wt(1);
        power_button_n_i <= 1'h0;
        wt(DB + OV + 20);
        power_button_n_i <= 1'h1;
        #1;
        `CHK("mgmt disabled", 1'h1, mgmt_irq_n_o)
        `CHK("soft off", 1'h1, soft_off_o)
        rd(ST);
        `CHK("override status", 3'h4, rd_v[2:0])
        wr(ST, 32'h4);
        rd(ST);
        `CHK("w1c", 3'h0, rd_v[2:0])
        // Reset in mid-run drops the sticky request
        wt(1);
        rst_i <= 1'h1;
        wt(3);
        rst_i <= 1'h0;
        #1;
        `CHK("soft off reset", 1'h0, soft_off_o)
        close_out();
    end
endmodule : system_mgmt_interrupt_gen_test
`default_nettype wire
